/* sgps_pkg.sv */
// Purpose: Shared constants and types for the switchgear position supervisor.
// Assumes: One 25 MHz system clock; all timer limits are given in clock ticks.
// Notes: Position codes and contact modes are shared with the surrounding logic.
package sgps_pkg;

  // Timer width; limits and counters use it.
  localparam int CNT_W = 16;

  // Two-bit position codes.
  localparam logic [1:0] POS_INDET = 2'h0;
  localparam logic [1:0] POS_OPEN = 2'h1;
  localparam logic [1:0] POS_CLOSED = 2'h2;
  localparam logic [1:0] POS_DISTURB = 2'h3;

  // Contact wiring modes on cfg_mode_i.
  localparam logic [1:0] MODE_BOTH = 2'h0;
  localparam logic [1:0] MODE_CLOSE_ONLY = 2'h1;
  localparam logic [1:0] MODE_OPEN_ONLY = 2'h2;

  // Values after reset.
  localparam logic [1:0] RST_CODE = 2'h0;
  localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;

  // Bit positions of the two contacts inside the synchroniser words.
  localparam int BIT_CLOSE = 1;
  localparam int BIT_OPEN = 0;

  // Smallest timer load; a zero travel limit still gives one tick.
  localparam logic [CNT_W-1:0] MIN_LOAD = 16'h0001;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MOVE,
    ST_SETTLE
  } sgps_state_t;

endpackage

/* sgps_supervisor.sv */
// Purpose: Validates switchgear position from auxiliary contacts and supervises commands.
// Assumes: Contact inputs are asynchronous pins; commands and settings are on sys_clk_i.
// Notes: All indications are registered; the position code follows the contacts by three clocks.
`timescale 1ns/100ps
module sgps_supervisor (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Auxiliary contacts from the switchgear.
  input wire logic aux_close_i,
  input wire logic aux_open_i,
  // Configuration.
  input wire logic [1:0] cfg_mode_i,
  input wire logic cfg_close_present_i,
  input wire logic cfg_open_present_i,
  input wire logic [sgps_pkg::CNT_W-1:0] move_on_limit_i,
  input wire logic [sgps_pkg::CNT_W-1:0] move_off_limit_i,
  input wire logic [sgps_pkg::CNT_W-1:0] settle_limit_i,
  // Commands.
  input wire logic cmd_close_i,
  input wire logic cmd_open_i,
  // Drive outputs to the command relays.
  output logic drive_close_o,
  output logic drive_open_o,
  // Validated position indications.
  output logic pos_on_o,
  output logic pos_off_o,
  output logic pos_indeterm_o,
  output logic pos_disturb_o,
  output logic [1:0] pos_code_o,
  output logic one_contact_flag_o,
  output logic command_success_o
);

  typedef struct packed {
    sgps_pkg::sgps_state_t state;
    logic [sgps_pkg::CNT_W-1:0] cnt;
    logic [sgps_pkg::CNT_W-1:0] drv_len;
    logic dir_close;
    logic superv;
    logic fail;
    logic assumed;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] raw_prev;
    logic [1:0] code;
    logic on;
    logic off;
    logic ind;
    logic dis;
    logic succ;
    logic drv_c;
    logic drv_o;
    logic one;
  } sgps_regs_t;

  sgps_regs_t s_q;
  sgps_regs_t s_d;

  // A zero limit would wrap to a 65536-tick count, so it is stretched to one tick.
  function automatic logic [sgps_pkg::CNT_W-1:0] sgps_load(
    input logic [sgps_pkg::CNT_W-1:0] lim
  );
    sgps_load = (lim == sgps_pkg::RST_CNT) ? sgps_pkg::MIN_LOAD : lim;
  endfunction

  logic close_v;
  logic open_v;
  logic need_c;
  logic need_o;
  logic unassigned;
  logic transit;
  logic [1:0] raw;
  logic [1:0] target;
  logic single;

  always_comb
  begin
    s_d = s_q;
    // Second stage only feeds logic; the first stage is read by nothing else.
    s_d.sync1 = {aux_close_i, aux_open_i};
    s_d.sync2 = s_q.sync1;
    close_v = s_q.sync2[sgps_pkg::BIT_CLOSE];
    open_v = s_q.sync2[sgps_pkg::BIT_OPEN];
    single = (cfg_mode_i != sgps_pkg::MODE_BOTH);
    need_c = (cfg_mode_i != sgps_pkg::MODE_OPEN_ONLY);
    need_o = (cfg_mode_i != sgps_pkg::MODE_CLOSE_ONLY);
    unassigned = (need_c && !cfg_close_present_i) || (need_o && !cfg_open_present_i)
                 || (cfg_mode_i == 2'h3);
    // Raw position from the contacts alone.
    if (cfg_mode_i == sgps_pkg::MODE_BOTH)
    begin
      if (close_v != open_v)
      begin
        raw = close_v ? sgps_pkg::POS_CLOSED : sgps_pkg::POS_OPEN;
      end
      else
      begin
        raw = sgps_pkg::POS_DISTURB;
      end
    end
    else if (cfg_mode_i == sgps_pkg::MODE_CLOSE_ONLY)
    begin
      raw = close_v ? sgps_pkg::POS_CLOSED : sgps_pkg::POS_OPEN;
    end
    else
    begin
      raw = open_v ? sgps_pkg::POS_OPEN : sgps_pkg::POS_CLOSED;
    end
    target = s_q.dir_close ? sgps_pkg::POS_CLOSED : sgps_pkg::POS_OPEN;
    s_d.raw_prev = raw;
    s_d.succ = 1'b0;
    // A held failure or assumed end position lasts until the contacts move or a new command is taken.
    if (raw != s_q.raw_prev)
    begin
      s_d.fail = 1'b0;
      s_d.assumed = 1'b0;
    end
    case (s_q.state)
      sgps_pkg::ST_IDLE:
      begin
        // Open wins over close; a command to the present position is dropped.
        if (!unassigned && cmd_open_i && raw != sgps_pkg::POS_OPEN)
        begin
          s_d.state = sgps_pkg::ST_MOVE;
          s_d.dir_close = 1'b0;
          s_d.cnt = sgps_load(move_off_limit_i);
          s_d.superv = (cfg_mode_i != sgps_pkg::MODE_CLOSE_ONLY);
          s_d.fail = 1'b0;
          s_d.assumed = 1'b0;
        end
        else if (!unassigned && cmd_close_i && raw != sgps_pkg::POS_CLOSED)
        begin
          s_d.state = sgps_pkg::ST_MOVE;
          s_d.dir_close = 1'b1;
          s_d.cnt = sgps_load(move_on_limit_i);
          s_d.superv = (cfg_mode_i != sgps_pkg::MODE_OPEN_ONLY);
          s_d.fail = 1'b0;
          s_d.assumed = 1'b0;
        end
      end
      sgps_pkg::ST_MOVE:
      begin
        if (raw == target)
        begin
          // Arrival ends the drive early and reports success when the move is supervised.
          s_d.state = sgps_pkg::ST_IDLE;
          s_d.succ = s_q.superv;
        end
        else if (s_q.cnt == sgps_pkg::MIN_LOAD)
        begin
          s_d.state = sgps_pkg::ST_IDLE;
          if (s_q.superv && single && settle_limit_i != sgps_pkg::RST_CNT)
          begin
            s_d.state = sgps_pkg::ST_SETTLE;
            s_d.cnt = settle_limit_i;
          end
          else if (s_q.superv)
          begin
            s_d.fail = 1'b1;
          end
        end
        else
        begin
          s_d.cnt = s_q.cnt - sgps_pkg::MIN_LOAD;
        end
      end
      sgps_pkg::ST_SETTLE:
      begin
        if (s_q.cnt == sgps_pkg::MIN_LOAD)
        begin
          s_d.state = sgps_pkg::ST_IDLE;
          s_d.assumed = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt - sgps_pkg::MIN_LOAD;
        end
      end
      default:
      begin
        s_d.state = sgps_pkg::ST_IDLE;
      end
    endcase
    // Indications follow the next state so that they line up with the drives.
    transit = (s_d.state == sgps_pkg::ST_MOVE && s_d.superv)
              || (s_d.state == sgps_pkg::ST_SETTLE);
    if (unassigned)
    begin
      s_d.code = sgps_pkg::POS_DISTURB;
    end
    else if (transit)
    begin
      s_d.code = sgps_pkg::POS_INDET;
    end
    else if (s_d.fail)
    begin
      s_d.code = sgps_pkg::POS_DISTURB;
    end
    else if (s_d.assumed)
    begin
      s_d.code = s_d.dir_close ? sgps_pkg::POS_CLOSED : sgps_pkg::POS_OPEN;
    end
    else
    begin
      s_d.code = raw;
    end
    s_d.ind = transit && !unassigned;
    s_d.on = (s_d.code == sgps_pkg::POS_CLOSED);
    s_d.off = (s_d.code == sgps_pkg::POS_OPEN);
    s_d.dis = (s_d.code == sgps_pkg::POS_DISTURB);
    s_d.drv_c = (s_d.state == sgps_pkg::ST_MOVE) && s_d.dir_close;
    s_d.drv_o = (s_d.state == sgps_pkg::ST_MOVE) && !s_d.dir_close;
    s_d.one = single;
    s_d.drv_len = (s_d.drv_c || s_d.drv_o) ? s_q.drv_len + sgps_pkg::MIN_LOAD : sgps_pkg::RST_CNT;
    if (!rst_n_i)
    begin
      s_d = '0;
      s_d.state = sgps_pkg::ST_IDLE;
      s_d.code = sgps_pkg::RST_CODE;
      s_d.cnt = sgps_pkg::RST_CNT;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    s_q <= s_d;
  end

  assign drive_close_o = s_q.drv_c;
  assign drive_open_o = s_q.drv_o;
  assign pos_on_o = s_q.on;
  assign pos_off_o = s_q.off;
  assign pos_indeterm_o = s_q.ind;
  assign pos_disturb_o = s_q.dis;
  assign pos_code_o = s_q.code;
  assign one_contact_flag_o = s_q.one;
  assign command_success_o = s_q.succ;

  // Checks on the indications and drives.
  property p_code_closed;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    pos_on_o |-> (pos_code_o == 2'h2) && !pos_off_o && !pos_indeterm_o && !pos_disturb_o;
  endproperty
  a_code_closed: assert property (p_code_closed) else $error("closed code mismatch");

  property p_code_disturb;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    pos_disturb_o == (pos_code_o == 2'h3);
  endproperty
  a_code_disturb: assert property (p_code_disturb) else $error("disturb code mismatch");

  property p_transit_only;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    pos_indeterm_o |-> (pos_code_o == 2'h0) && !pos_on_o && !pos_off_o && !pos_disturb_o;
  endproperty
  a_transit_only: assert property (p_transit_only) else $error("transit not exclusive");

  property p_one_flag;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 one_contact_flag_o == ($past(cfg_mode_i) != 2'h0);
  endproperty
  a_one_flag: assert property (p_one_flag) else $error("one-contact flag wrong");

  property p_close_start;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(drive_close_o) && cfg_mode_i != 2'h2 |-> pos_indeterm_o;
  endproperty
  a_close_start: assert property (p_close_start) else $error("no transit on close");

  property p_success_pos;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    command_success_o |-> (pos_on_o || pos_off_o) && !drive_close_o && !drive_open_o;
  endproperty
  a_success_pos: assert property (p_success_pos) else $error("success without end position");

  property p_drive_len;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (drive_close_o && $stable(move_on_limit_i)) |-> s_q.drv_len <= sgps_load(move_on_limit_i);
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("close drive too long");

  property p_drive_excl;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !(drive_close_o && drive_open_o) && !(pos_on_o && pos_off_o);
  endproperty
  a_drive_excl: assert property (p_drive_excl) else $error("conflicting outputs");

  property p_unassigned;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (cfg_mode_i == 2'h1 && !cfg_close_present_i)[*2] |-> pos_code_o == 2'h3;
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("missing close input not disturbed");

  property p_unassigned_open;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (cfg_mode_i == 2'h2 && !cfg_open_present_i)[*2] |-> pos_code_o == 2'h3;
  endproperty
  a_unassigned_open: assert property (p_unassigned_open) else $error("missing open input");

endmodule

/* sgps_gear_model.sv */
// Purpose: Behavioural switchgear with two auxiliary contacts, driven by the relay outputs.
// Assumes: Travel delay in clock ticks is set per command by the bench.
// Notes: A stuck gear never moves, which is how timeouts are provoked.
`timescale 1ns/100ps
module sgps_gear_model (
  // Clock.
  input wire logic sys_clk_i,
  // Relay drives and test controls.
  input wire logic drive_close_i,
  input wire logic drive_open_i,
  input wire logic stuck_i,
  input wire logic [7:0] delay_i,
  // Auxiliary contacts.
  output logic aux_close_o,
  output logic aux_open_o
);
  logic closed_q = 1'b0;
  int busy_q = 0;
  always @(posedge sys_clk_i)
  begin
    if (busy_q > 1)
      busy_q <= busy_q - 1;
    else if (busy_q == 1)
    begin
      closed_q <= ~closed_q;
      busy_q <= 0;
    end
    else if (!stuck_i && ((drive_close_i && !closed_q) || (drive_open_i && closed_q)))
      busy_q <= int'(delay_i);
  end
  // Mid-travel both contacts are open, so a real linkage never shows two positions at once.
  assign aux_close_o = closed_q && busy_q == 0;
  assign aux_open_o = !closed_q && busy_q == 0;
endmodule

/* test_sgps_supervisor.sv */
// Purpose: Self-checking bench for the switchgear position supervisor.
// Assumes: Close travel limit 20 ticks, open 18; the gear answers in 2, 12 or 40 ticks.
// Notes: Each command is watched for a fixed 60 cycles, longer than travel plus settle.
`timescale 1ns/100ps
module test_sgps_supervisor;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic stuck = 1'b0;
  logic [7:0] delay = 8'h02;
  logic [1:0] mode = 2'h0;
  logic cp = 1'b1, op = 1'b1, cc = 1'b0, co = 1'b0;
  logic [15:0] settle = 16'h0000;
  // Unequal limits so that a swapped close and open timer shows up.
  logic [15:0] on_lim = 16'h0014;
  logic [15:0] off_lim = 16'h0012;
  logic ax_c, ax_o, dc, dop, pon, poff, pind, pdis, flag, succ;
  logic [1:0] code, mid_code, late_code;
  logic [15:0] drv_n;
  logic saw_ind, saw_succ, saw_stl;
  int bad_count = 0, total_checks = 0, cyc = 0;

  sgps_gear_model u_gear (.sys_clk_i(sys_clk_i), .drive_close_i(dc), .drive_open_i(dop),
    .stuck_i(stuck), .delay_i(delay), .aux_close_o(ax_c), .aux_open_o(ax_o));
  sgps_supervisor u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .aux_close_i(ax_c),
    .aux_open_i(ax_o), .cfg_mode_i(mode), .cfg_close_present_i(cp), .cfg_open_present_i(op),
    .move_on_limit_i(on_lim), .move_off_limit_i(off_lim), .settle_limit_i(settle),
    .cmd_close_i(cc), .cmd_open_i(co), .drive_close_o(dc), .drive_open_o(dop),
    .pos_on_o(pon), .pos_off_o(poff), .pos_indeterm_o(pind), .pos_disturb_o(pdis),
    .pos_code_o(code), .one_contact_flag_o(flag), .command_success_o(succ));

  initial forever #20 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic set_cfg(input logic [1:0] m, input logic c, input logic o);
    @(posedge sys_clk_i);
    mode <= m;
    cp <= c;
    op <= o;
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask

  // One command, then 60 cycles of watching drive, transit, success and settle.
  task automatic run_cmd(input logic close, input logic stk, input logic [7:0] dly,
    input logic [15:0] stl);
    @(posedge sys_clk_i);
    stuck <= stk;
    delay <= dly;
    settle <= stl;
    cc <= close;
    co <= !close;
    @(posedge sys_clk_i);
    cc <= 1'b0;
    co <= 1'b0;
    drv_n = 16'h0000;
    saw_ind = 1'b0;
    saw_succ = 1'b0;
    saw_stl = 1'b0;
    mid_code = 2'h3;
    late_code = 2'h0;
    // Sampling starts just after the taking edge, so the first drive cycle is counted too.
    for (int i = 0; i < 60; i++)
    begin
      #1;
      if (dc === 1'b1 || dop === 1'b1)
        drv_n++;
      if ((dc === 1'b1 || dop === 1'b1) && drv_n == 16'h0008)
        mid_code = code;
      if (i == 30)
        late_code = code;
      if (pind === 1'b1 && dc !== 1'b1 && dop !== 1'b1 && drv_n != 16'h0000)
        saw_stl = 1'b1;
      saw_ind = saw_ind | (pind === 1'b1);
      saw_succ = saw_succ | (succ === 1'b1);
      @(posedge sys_clk_i);
    end
    #1;
  endtask

  task automatic t_both;
    run_cmd(1'b1, 1'b1, 8'h02, 16'h0000);
    chk("drive_len", drv_n, 16'h0014);
    chk("code_to", {14'h0, code}, 16'h0003);
    chk("dist_to", {12'h0, pdis, pind, pon, poff}, 16'h0008);
    run_cmd(1'b1, 1'b0, 8'h0c, 16'h0000);
    chk("mid_code", {14'h0, mid_code}, 16'h0000);
    chk("succ_on", {15'h0, saw_succ}, 16'h0001);
    chk("code_on", {14'h0, code}, 16'h0002);
    chk("ind_on", {12'h0, pdis, pind, pon, poff}, 16'h0002);
    chk("drv_early", {15'h0, drv_n < 16'h0014}, 16'h0001);
    run_cmd(1'b0, 1'b0, 8'h02, 16'h0000);
    chk("succ_off", {15'h0, saw_succ}, 16'h0001);
    chk("ind_off", {12'h0, pdis, pind, pon, poff}, 16'h0001);
    chk("code_off", {14'h0, code}, 16'h0001);
    // Gear slower than the limit, so both contacts read 0 once the timer has expired.
    run_cmd(1'b1, 1'b0, 8'h28, 16'h0000);
    chk("code_equal", {14'h0, late_code}, 16'h0003);
    chk("code_late", {14'h0, code}, 16'h0002);
    run_cmd(1'b0, 1'b0, 8'h02, 16'h0000);
    chk("succ_back", {15'h0, saw_succ}, 16'h0001);
    $display("t_both finished");
  endtask

  task automatic t_open_only;
    set_cfg(2'h2, 1'b1, 1'b1);
    chk("flag", {15'h0, flag}, 16'h0001);
    run_cmd(1'b1, 1'b0, 8'h02, 16'h0000);
    chk("unsup", {14'h0, saw_ind, saw_succ}, 16'h0000);
    chk("oo_code_on", {14'h0, code}, 16'h0002);
    run_cmd(1'b0, 1'b0, 8'h02, 16'h0000);
    chk("oo_succ", {15'h0, saw_succ}, 16'h0001);
    chk("oo_code", {14'h0, code}, 16'h0001);
    run_cmd(1'b1, 1'b0, 8'h02, 16'h0000);
    run_cmd(1'b0, 1'b1, 8'h02, 16'h0008);
    chk("oo_drv_len", drv_n, 16'h0012);
    chk("oo_settle", {15'h0, saw_stl}, 16'h0001);
    chk("oo_after", {14'h0, code}, 16'h0001);
    run_cmd(1'b0, 1'b0, 8'h02, 16'h0000);
    $display("t_open_only finished");
  endtask

  task automatic t_close_only;
    set_cfg(2'h1, 1'b1, 1'b1);
    run_cmd(1'b1, 1'b0, 8'h02, 16'h0000);
    chk("co_succ", {15'h0, saw_succ}, 16'h0001);
    chk("co_code", {13'h0, code, pon}, 16'h0005);
    run_cmd(1'b0, 1'b0, 8'h02, 16'h0000);
    chk("co_unsup", {14'h0, saw_ind, saw_succ}, 16'h0000);
    chk("co_open", {14'h0, code}, 16'h0001);
    run_cmd(1'b1, 1'b1, 8'h02, 16'h0000);
    chk("co_fail", {13'h0, code, pind}, 16'h0006);
    run_cmd(1'b1, 1'b1, 8'h02, 16'h0008);
    chk("co_settle", {15'h0, saw_stl}, 16'h0001);
    chk("co_after", {14'h0, code}, 16'h0002);
    $display("t_close_only finished");
  endtask

  task automatic t_unassigned;
    set_cfg(2'h1, 1'b0, 1'b1);
    chk("no_close", {14'h0, code}, 16'h0003);
    set_cfg(2'h2, 1'b1, 1'b0);
    chk("no_open", {14'h0, code}, 16'h0003);
    run_cmd(1'b1, 1'b0, 8'h02, 16'h0000);
    chk("no_drive", drv_n, 16'h0000);
    $display("t_unassigned finished");
  endtask

  // Whole run is about 960 cycles; the ceiling leaves ample margin.
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      stop_test;
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    t_both;
    t_open_only;
    t_close_only;
    t_unassigned;
    stop_test;
  end
endmodule
